// File: rtl/ce_port_top.sv
// Option-selected 4-bit C/E/CE port with APB register access.
// Assumes an APB master on pclk; pins and comparators are asynchronous.
//
// What this block does
// RL1: Output-only kind drives four pins, no input.
// RL2: Output data at index 04h, reset zero, drives pins.
// RL3: Input-only kind: data at index 0Eh reads pins.
// RL4: Option picks input-only or bidirectional input side.
// RL5: Bidirectional bits follow direction register bits.
// RL6: No comparator options gives plain digital port.
// RL7: Both comparator options give two-comparator mode.
// RL8: Comparator one output reads on bit 0.
// RL9: Bit 1 reads zero under its option.
// RL10: Comparator two output reads on bit 2.
// RL11: Bit 3 reads zero under its option.
// RL12: Software keeps comparator two off with op-amp.
// RL13: Op-amp mode with comparator one reads bits 2 and 3 zero.
// RL14: Software keeps gain enable off with op-amp.
// RL15: Per-bit option forces output pins high.
// RL16: Per-bit option makes output low weak.
// RL17: Per-bit option enables wake on input side.
// RL18: Option selects output-only or input-side kind.
// RL19: Options lock after first write; read mux combinational.
`timescale 1ns/1ps
`include "ce_port_defs.svh"
module ce_port_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic [3:0] pin_weak,
    input wire logic cmp1_in,
    input wire logic cmp2_in,
    output logic cmp1_en,
    output logic cmp2_en,
    output logic opamp_en,
    output logic gain_en,
    output logic wake_o
);
    import ce_port_pkg::*;

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [5:0] sync_out;
    logic [3:0] pins_s;
    logic cmp1_s;
    logic cmp2_s;

    // Pins and comparator outputs share one synchroniser
    ce_sync3 #(
        .W(6)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({cmp2_in, cmp1_in, pin_in}),
        .dout(sync_out)
    );
    assign pins_s = sync_out[3:0];
    assign cmp1_s = sync_out[4];
    assign cmp2_s = sync_out[5];

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [3:0] out_data_q, out_data_d;
    logic [3:0] in_data_q, in_data_d;
    logic [3:0] dir_q, dir_d;
    opt_t opt_q, opt_d;
    logic lock_q, lock_d;
    logic [31:0] prdata_q, prdata_d;
    logic [3:0] prev_q, prev_d;
    logic wake_q, wake_d;
    port_kind_t kind;
    logic [3:0] rd_val;

    // ----------------------------------------
    // Port kind decode
    // ----------------------------------------
    // Either bidirectional option turns the input side into CE
    always_comb begin
        if (!opt_q.kind_sel) begin
            kind = KIND_OUT; // see RL18
        end else if (opt_q.bidir || opt_q.in_bidir) begin
            kind = KIND_BIDIR; // see RL4
        end else begin
            kind = KIND_IN; // see RL4
        end
    end

    // Read path is purely combinational on the chosen sources
    ce_read_mux u_mux (
        .opt(opt_q),
        .kind(kind),
        .pins(pins_s),
        .cmp1(cmp1_s),
        .cmp2(cmp2_s),
        .val(rd_val)
    );

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic idx_ok;
    logic [7:0] idx;
    logic hit_out, hit_in, hit_dir, hit_opt, hit_stat;
    logic wr_en, rd_setup, bad;

    assign idx = paddr[9:2];
    assign idx_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign hit_out = idx_ok && (idx == `OUT_DATA_IDX);
    assign hit_in = idx_ok && (idx == `IN_DATA_IDX);
    assign hit_dir = idx_ok && (idx == `DIR_IDX);
    assign hit_opt = idx_ok && (idx == `OPT_IDX);
    assign hit_stat = idx_ok && (idx == `STAT_IDX);
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    // Locked option writes are refused, so the options cannot drift
    assign bad = !(hit_out || hit_in || hit_dir || hit_opt || hit_stat)
        || (hit_opt && pwrite && lock_q);

    // Zero wait states keep the port path simple
    assign pready = 1'b1;
    assign pslverr = psel && penable && bad;

    // ----------------------------------------
    // Register next state
    // ----------------------------------------
    // Read data is captured in the setup cycle so it is a flop output
    always_comb begin
        out_data_d = out_data_q;
        in_data_d = in_data_q;
        dir_d = dir_q;
        opt_d = opt_q;
        lock_d = lock_q;
        prdata_d = prdata_q;
        if (wr_en && hit_out) begin
            out_data_d = pwdata[3:0]; // see RL2
        end
        if (wr_en && hit_in) begin
            in_data_d = pwdata[3:0];
        end
        if (wr_en && hit_dir) begin
            dir_d = pwdata[3:0]; // see RL5
        end
        if (wr_en && hit_opt && !lock_q) begin
            opt_d.kind_sel = pwdata[`OPT_KIND_BIT];
            opt_d.bidir = pwdata[`OPT_BIDIR_BIT];
            opt_d.in_bidir = pwdata[`OPT_INBIDIR_BIT];
            opt_d.cmp1 = pwdata[`OPT_CMP1_BIT]; // see RL7
            opt_d.cmp2 = pwdata[`OPT_CMP2_BIT]; // see RL7
            opt_d.opamp = pwdata[`OPT_OPAMP_BIT];
            opt_d.bit1_read_zero_option = pwdata[`OPT_BIT1_READ_ZERO_OPTION_BIT];
            opt_d.bit3_read_zero_option = pwdata[`OPT_BIT3_READ_ZERO_OPTION_BIT];
            opt_d.gain = pwdata[`OPT_GAIN_BIT];
            opt_d.force_high = pwdata[`OPT_FH_LSB +: 4];
            opt_d.weak_low = pwdata[`OPT_WL_LSB +: 4];
            opt_d.wake_en = pwdata[`OPT_WK_LSB +: 4];
            lock_d = 1'b1; // see RL19
        end
        if (rd_setup) begin
            prdata_d = 32'h0000_0000;
            if (hit_out) begin
                prdata_d[3:0] = out_data_q;
            end
            if (hit_in) begin
                prdata_d[3:0] = rd_val; // see RL3
            end
            if (hit_dir) begin
                prdata_d[3:0] = dir_q;
            end
            if (hit_opt) begin
                prdata_d[`OPT_KIND_BIT] = opt_q.kind_sel;
                prdata_d[`OPT_BIDIR_BIT] = opt_q.bidir;
                prdata_d[`OPT_INBIDIR_BIT] = opt_q.in_bidir;
                prdata_d[`OPT_CMP1_BIT] = opt_q.cmp1;
                prdata_d[`OPT_CMP2_BIT] = opt_q.cmp2;
                prdata_d[`OPT_OPAMP_BIT] = opt_q.opamp;
                prdata_d[`OPT_BIT1_READ_ZERO_OPTION_BIT] = opt_q.bit1_read_zero_option;
                prdata_d[`OPT_BIT3_READ_ZERO_OPTION_BIT] = opt_q.bit3_read_zero_option;
                prdata_d[`OPT_GAIN_BIT] = opt_q.gain;
                prdata_d[`OPT_FH_LSB +: 4] = opt_q.force_high;
                prdata_d[`OPT_WL_LSB +: 4] = opt_q.weak_low;
                prdata_d[`OPT_WK_LSB +: 4] = opt_q.wake_en;
                prdata_d[`OPT_LOCK_BIT] = lock_q;
            end
            if (hit_stat) begin
                prdata_d[3:0] = pins_s;
                prdata_d[5:4] = kind;
                prdata_d[6] = cmp1_s;
                prdata_d[7] = cmp2_s;
            end
        end
    end

    // ----------------------------------------
    // Wake detect next state
    // ----------------------------------------
    // Rising edge on an enabled input-side pin; output kind never wakes
    always_comb begin
        prev_d = pins_s;
        wake_d = (kind != KIND_OUT)
            && (|(pins_s & ~prev_q & opt_q.wake_en)); // see RL17
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data_q <= `OUT_DATA_RST;
            in_data_q <= `IN_DATA_RST;
            dir_q <= `DIR_RST;
            opt_q <= '0;
            lock_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            prev_q <= 4'h0;
            wake_q <= 1'b0;
        end else begin
            out_data_q <= out_data_d;
            in_data_q <= in_data_d;
            dir_q <= dir_d;
            opt_q <= opt_d;
            lock_q <= lock_d;
            prdata_q <= prdata_d;
            prev_q <= prev_d;
            wake_q <= wake_d;
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    logic [3:0] drive_val;
    // Output kind drives all four; weak low flags low bits to the pad
    always_comb begin
        drive_val = 4'h0;
        pin_oe_n = 4'hF;
        pin_weak = 4'h0;
        case (kind)
            KIND_OUT: begin
                drive_val = out_data_q | opt_q.force_high; // see RL15
                pin_oe_n = 4'h0; // see RL1
                pin_weak = opt_q.weak_low & ~drive_val; // see RL16
            end
            KIND_IN: begin
                pin_oe_n = 4'hF; // see RL3
            end
            KIND_BIDIR: begin
                drive_val = in_data_q;
                pin_oe_n = ~dir_q; // see RL5
            end
            default: begin
                pin_oe_n = 4'hF;
            end
        endcase
    end

    assign pin_out = drive_val;
    assign prdata = prdata_q;
    assign wake_o = wake_q;
    // Comparator and op-amp enables follow options only in bidirectional kind, gain in any kind; software must avoid bad combinations
    assign cmp1_en = opt_q.cmp1 && (kind == KIND_BIDIR);
    assign cmp2_en = opt_q.cmp2 && (kind == KIND_BIDIR);
    assign opamp_en = opt_q.opamp && (kind == KIND_BIDIR);
    assign gain_en = opt_q.gain;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_in;
    assign rd_in = rd_setup && hit_in && (kind == KIND_BIDIR);

    out_drive_a: assert property ( // see RL2
        (kind == KIND_OUT) |-> (pin_oe_n == 4'h0)
        && (pin_out == (out_data_q | opt_q.force_high)))
        else $error("output kind pins wrong");
    out_write_a: assert property ( // see RL2
        (wr_en && hit_out && kind == KIND_OUT && opt_q.force_high == 4'h0)
        |=> (pin_out == $past(pwdata[3:0])))
        else $error("output write not on pins");
    in_only_a: assert property ( // see RL3
        (kind == KIND_IN) |-> (pin_oe_n == 4'hF))
        else $error("input kind drives pins");
    in_read_a: assert property ( // see RL3
        (rd_setup && hit_in && kind == KIND_IN) |=> (prdata[3:0] == $past(pins_s)))
        else $error("input read not pins");
    bidir_dir_a: assert property ( // see RL5
        (kind == KIND_BIDIR) |-> (pin_oe_n == ~dir_q))
        else $error("direction not followed");
    plain_read_a: assert property ( // see RL6
        (rd_in && !opt_q.cmp1 && !opt_q.cmp2 && !opt_q.opamp)
        |=> (prdata[3:0] == $past(pins_s)))
        else $error("plain read altered");
    cmp_one_a: assert property ( // see RL8
        (rd_in && opt_q.cmp1) |=> (prdata[0] == $past(cmp1_s)))
        else $error("comparator one not on bit 0");
    bit1_zero_a: assert property ( // see RL9
        (rd_in && opt_q.cmp1 && opt_q.bit1_read_zero_option) |=> (prdata[1] == 1'b0))
        else $error("bit 1 not zero");
    cmp_two_a: assert property ( // see RL10
        (rd_in && opt_q.cmp2 && !opt_q.opamp) |=> (prdata[2] == $past(cmp2_s)))
        else $error("comparator two not on bit 2");
    bit3_zero_a: assert property ( // see RL11
        (rd_in && opt_q.cmp2 && !opt_q.opamp && opt_q.bit3_read_zero_option) |=> (prdata[3] == 1'b0))
        else $error("bit 3 not zero");
    opamp_zero_a: assert property ( // see RL13
        (rd_in && opt_q.cmp1 && opt_q.opamp) |=> (prdata[3:2] == 2'b00))
        else $error("op-amp bits not zero");
    force_high_a: assert property ( // see RL15
        (kind == KIND_OUT) |-> ((pin_out & opt_q.force_high) == opt_q.force_high))
        else $error("forced bit not high");
    weak_low_a: assert property ( // see RL16
        (kind == KIND_OUT) |-> (pin_weak == (opt_q.weak_low & ~pin_out)))
        else $error("weak low wrong");
    wake_edge_a: assert property ( // see RL17
        wake_o |-> ($past(kind) != KIND_OUT)
        && (|($past(pins_s) & ~$past(prev_q) & $past(opt_q.wake_en))))
        else $error("wake without enabled edge");
    opt_fixed_a: assert property ( // see RL19
        lock_q |=> $stable(opt_q) [*2])
        else $error("options changed after lock");
    lock_refuse_a: assert property ( // see RL19
        (wr_en && hit_opt && lock_q) |-> pslverr ##1 $stable(opt_q))
        else $error("locked option write taken");
    two_cmp_a: assert property ( // see RL7
        (kind == KIND_BIDIR && opt_q.cmp1 && opt_q.cmp2) |-> (cmp1_en && cmp2_en))
        else $error("two-comparator mode not enabled");
    in_side_a: assert property ( // see RL4
        (opt_q.kind_sel && !opt_q.bidir && !opt_q.in_bidir) |-> (pin_oe_n == 4'hF))
        else $error("input-only side drives pins");
endmodule

// File: rtl/ce_port_defs.svh
// Register indices, field positions and reset values of the CE port block.
// Assumes inclusion from the top module and the bench only.
`ifndef CE_PORT_DEFS_SVH
`define CE_PORT_DEFS_SVH
// Register indices; byte address is four times the index
`define OUT_DATA_IDX 8'h04
`define IN_DATA_IDX 8'h0E
`define DIR_IDX 8'h0F
`define OPT_IDX 8'h20
`define STAT_IDX 8'h21
// Option word field positions
`define OPT_KIND_BIT 0
`define OPT_BIDIR_BIT 1
`define OPT_INBIDIR_BIT 2
`define OPT_CMP1_BIT 3
`define OPT_CMP2_BIT 4
`define OPT_OPAMP_BIT 5
`define OPT_BIT1_READ_ZERO_OPTION_BIT 6
`define OPT_BIT3_READ_ZERO_OPTION_BIT 7
`define OPT_GAIN_BIT 8
`define OPT_FH_LSB 12
`define OPT_WL_LSB 16
`define OPT_WK_LSB 20
`define OPT_LOCK_BIT 31
// Reset values
`define OUT_DATA_RST 4'h0
`define IN_DATA_RST 4'h0
`define DIR_RST 4'h0
`endif

// File: rtl/ce_port_pkg.sv
// Types shared by the CE port block.
// Assumes the defs header sits beside it.
package ce_port_pkg;
    typedef struct packed {
        logic kind_sel;
        logic bidir;
        logic in_bidir;
        logic cmp1;
        logic cmp2;
        logic opamp;
        logic bit1_read_zero_option;
        logic bit3_read_zero_option;
        logic gain;
        logic [3:0] force_high;
        logic [3:0] weak_low;
        logic [3:0] wake_en;
    } opt_t;
    typedef enum logic [1:0] {
        KIND_OUT = 2'b00,
        KIND_IN = 2'b01,
        KIND_BIDIR = 2'b10
    } port_kind_t;
endpackage

// File: rtl/ce_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs asynchronous to pclk.
`timescale 1ns/1ps
module ce_sync3 #(
    parameter int W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;
    // A bit changes only once stages two and three agree
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end
    // Stage one feeds stage two only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end
    assign dout = out_q;
endmodule

// File: rtl/ce_read_mux.sv
// Read value of the input-side data register with comparator routing.
// Assumes all inputs already synchronised to pclk.
`timescale 1ns/1ps
module ce_read_mux (
    input wire ce_port_pkg::opt_t opt,
    input wire ce_port_pkg::port_kind_t kind,
    input wire logic [3:0] pins,
    input wire logic cmp1,
    input wire logic cmp2,
    output logic [3:0] val
);
    import ce_port_pkg::*;
    // Comparator outputs replace pin bits; read-zero options mask bits
    always_comb begin
        val = pins; // see RL6
        if (kind == KIND_OUT) begin
            val = 4'h0; // see RL1
        end else if (kind == KIND_BIDIR) begin
            if (opt.cmp1) begin
                val[0] = cmp1; // see RL8
                val[1] = opt.bit1_read_zero_option ? 1'b0 : pins[1]; // see RL9
            end
            if (opt.cmp2 && !opt.opamp) begin
                val[2] = cmp2; // see RL10
                val[3] = opt.bit3_read_zero_option ? 1'b0 : pins[3]; // see RL11
            end
            if (opt.opamp && opt.cmp1) begin
                val[3:2] = 2'b00; // see RL13
            end
        end
    end
endmodule

// File: test/pin_side_model.sv
// Model of the far side of the port: the pins and the two comparator outputs.
// Assumes the bench sets the external levels and the analog results.
`timescale 1ns/1ps
module pin_side_model (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe_n,
    input wire logic [3:0] ext_lvl,
    input wire logic c1_lvl,
    input wire logic c2_lvl,
    output logic [3:0] pin_in,
    output logic cmp1_in,
    output logic cmp2_in
);
    // -------------------------------------------------
    // Pin wire resolution
    // -------------------------------------------------
    // A driven pin shows the block's level; an input pin shows the outside world
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
        end
    end

    // Comparator results come straight from the analog side
    assign cmp1_in = c1_lvl;
    assign cmp2_in = c2_lvl;
endmodule

// File: test/tb_top.sv
// Self-checking bench of the CE port block over APB.
// Assumes the design files and the pin model are compiled before it.
`timescale 1ns/1ps
`include "ce_port_defs.svh"
module tb_top;
    // Byte address is the register index times four
    localparam logic [11:0] A_OUT = {2'b00, `OUT_DATA_IDX, 2'b00};
    localparam logic [11:0] A_IN = {2'b00, `IN_DATA_IDX, 2'b00};
    localparam logic [11:0] A_DIR = {2'b00, `DIR_IDX, 2'b00};
    localparam logic [11:0] A_OPT = {2'b00, `OPT_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, `STAT_IDX, 2'b00};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, cmp1_in, cmp2_in, cmp1_en, cmp2_en, opamp_en, gain_en, wake_o;
    logic [3:0] pin_in, pin_out, pin_oe_n, pin_weak, ext_lvl = 4'h0, e;
    logic c1_lvl = 1'b0, c2_lvl = 1'b0;
    logic [4:0] cfg [6] = '{5'h00, 5'h12, 5'h19, 5'h08, 5'h14, 5'h16};
    int miscompares = 0, cmp_count = 0;

    always #2.5 pclk = ~pclk;

    ce_port_top ce_port_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_weak(pin_weak),
        .cmp1_in(cmp1_in), .cmp2_in(cmp2_in), .cmp1_en(cmp1_en), .cmp2_en(cmp2_en),
        .opamp_en(opamp_en), .gain_en(gain_en), .wake_o(wake_o));

    pin_side_model pin_side_model_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_lvl(ext_lvl), .c1_lvl(c1_lvl), .c2_lvl(c2_lvl), .pin_in(pin_in),
        .cmp1_in(cmp1_in), .cmp2_in(cmp2_in));

    // -------------------------------------------------
    // Helpers
    // -------------------------------------------------
    // Verdict and end of run, reached from the main flow and from timeouts
    task automatic give_verdict;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; a read compares data, every transfer compares the error flag
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic exp_err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                give_verdict();
            end
            @(posedge pclk);
        end
        if (!wr) chk(prdata, exp);
        chk({31'h0, pslverr}, {31'h0, exp_err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reset is held eight cycles; options unlock only through reset
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Far-side levels change after an edge; wait out the input synchroniser
    task automatic setin(input logic [3:0] p, input logic a, input logic b);
        @(posedge pclk);
        ext_lvl <= p;
        c1_lvl <= a;
        c2_lvl <= b;
        repeat (8) @(posedge pclk);
    endtask

    function automatic logic [31:0] optw(input logic [8:0] f, input logic [3:0] fh,
                                         input logic [3:0] wl, input logic [3:0] wk);
        optw = {8'h00, wk, wl, fh, 3'h0, f};
    endfunction

    // -------------------------------------------------
    // Main sequence
    // -------------------------------------------------
    initial begin
        do_reset();
        // Output-only kind straight after reset
        @(negedge pclk);
        chk({pin_oe_n, pin_out}, 8'h00);
        xfer(1'b0, A_OUT, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, A_OUT, 32'h5, 32'h0, 1'b0);
        @(negedge pclk);
        chk(pin_out, 4'h5);
        xfer(1'b1, A_OUT, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, A_OPT, optw(9'h000, 4'h1, 4'h2, 4'h0), 32'h0, 1'b0);
        @(negedge pclk);
        chk({pin_weak, pin_out}, 8'h21);
        xfer(1'b0, A_IN, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, A_OPT, 32'h1, 32'h0, 1'b1);
        xfer(1'b0, 12'h044, 32'h0, 32'h0, 1'b1);
        // Forced-high bit 0 drives its own pin, so the status sees it high
        xfer(1'b0, A_STAT, 32'h0, 32'h0000_0001, 1'b0);

        // Input-only kind with wake on bit 0 and the gain option
        do_reset();
        xfer(1'b1, A_OPT, optw(9'h101, 4'h0, 4'h0, 4'h1), 32'h0, 1'b0);
        setin(4'hA, 1'b0, 1'b0);
        chk({gain_en, pin_oe_n}, 5'h1F);
        xfer(1'b0, A_IN, 32'h0, 32'h0000000A, 1'b0);
        xfer(1'b0, A_STAT, 32'h0, 32'h0000001A, 1'b0);
        // A rise on a bit without wake enable stays quiet; count while it syncs
        @(posedge pclk);
        ext_lvl <= 4'hE;
        e = 4'h0;
        for (int i = 0; i < 12; i++) begin
            @(posedge pclk);
            e = e + {3'h0, wake_o === 1'b1};
        end
        chk(e, 4'h0);
        @(posedge pclk);
        ext_lvl <= 4'h0;
        repeat (8) @(posedge pclk);
        ext_lvl <= 4'h1;
        for (int i = 0; i < 12; i++) begin
            @(posedge pclk);
            e = e + {3'h0, wake_o === 1'b1};
        end
        chk(e, 4'h1);

        // Bidirectional through the input-side option, mixed directions
        do_reset();
        xfer(1'b1, A_OPT, optw(9'h005, 4'h0, 4'h0, 4'h0), 32'h0, 1'b0);
        xfer(1'b1, A_DIR, 32'h3, 32'h0, 1'b0);
        xfer(1'b0, A_DIR, 32'h0, 32'h3, 1'b0);
        xfer(1'b1, A_IN, 32'h2, 32'h0, 1'b0);
        setin(4'h4, 1'b1, 1'b1);
        chk({pin_oe_n, pin_out[1:0]}, 6'h32);
        xfer(1'b0, A_IN, 32'h0, 32'h6, 1'b0);
        xfer(1'b0, A_STAT, 32'h0, 32'hE6, 1'b0);

        // Comparator routing table; opamp rows keep cmp2 and gain off
        foreach (cfg[k]) begin
            do_reset();
            xfer(1'b1, A_OPT, optw({1'b0, cfg[k][0], cfg[k][1], cfg[k][2], cfg[k][3],
                cfg[k][4], 3'h3}, 4'h0, 4'h0, 4'h0), 32'h0, 1'b0);
            // Options land at the access edge; look once they have settled
            @(negedge pclk);
            chk({cmp1_en, cmp2_en, opamp_en}, cfg[k][4:2]);
            for (int s = 0; s < 2; s++) begin
                setin(s ? 4'h0 : 4'hF, s[0], s[0]);
                e = ext_lvl;
                e[0] = cfg[k][4] ? c1_lvl : e[0];
                e[1] = (cfg[k][4] & cfg[k][1]) ? 1'b0 : e[1];
                e[2] = (cfg[k][3] & !cfg[k][2]) ? c2_lvl : e[2];
                e[3] = (cfg[k][3] & !cfg[k][2] & cfg[k][0]) ? 1'b0 : e[3];
                e[3:2] = (cfg[k][2] & cfg[k][4]) ? 2'b00 : e[3:2];
                xfer(1'b0, A_IN, 32'h0, {28'h0, e}, 1'b0);
            end
        end
        give_verdict();
    end
endmodule
